/* logic/seeb_slave.sv */
// Purpose: two-wire slave front end of a serial memory
// Assumes: scl and sda far slower than i_mclk; read data supplied by array side
// Notes:   write cycle timing, roll-over and read sequencing live elsewhere
`timescale 1ns/100ps

module seeb_slave #(
    parameter int INIT_CYCLES = seeb_pkg::INIT_CYCLES
) (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic        i_power_good,
    input  wire logic        i_brownout,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe_n,
    input  wire logic        i_chip_select_strap_0,
    input  wire logic        i_chip_select_strap_1,
    input  wire logic        i_chip_select_strap_2,
    input  wire logic        i_write_protect,
    input  wire logic        i_id_locked,
    input  wire logic        i_busy,
    input  wire logic [7:0]  i_rd_data,
    output logic             o_rd_next,
    output logic [15:0]      o_word_addr,
    output logic [1:0]       o_sel,
    output logic [6:0]       o_id_offset,
    output logic [3:0]       o_uid_offset,
    output logic             o_rd_mode,
    output logic [7:0]       o_wr_data,
    output logic             o_wr_data_valid,
    output logic             o_program_start,
    output logic             o_standby,
    output logic             o_ready
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // three stages; a change counts when stages two and three agree
    logic [2:0] scl_sync_ff, sda_sync_ff, nxt_scl_sync, nxt_sda_sync;
    logic       scl_ff, sda_ff, nxt_scl, nxt_sda;
    logic       scl_rise, scl_fall, start_det, stop_det;
    logic [8:0] lvl_sync_ff, nxt_lvl_sync;
    logic [2:0] lvl_ff, nxt_lvl;
    logic       wp_sync, brownout_sync, power_good_sync;

    always_comb begin
        nxt_scl_sync = {scl_sync_ff[1:0], i_scl};
        nxt_sda_sync = {sda_sync_ff[1:0], i_sda};
        nxt_scl      = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_ff;
        nxt_sda      = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
        nxt_lvl_sync = {lvl_sync_ff[5:0], i_write_protect, i_brownout, i_power_good};
        nxt_lvl      = (lvl_sync_ff[5:3] & lvl_sync_ff[8:6]) | (lvl_ff & (lvl_sync_ff[5:3] | lvl_sync_ff[8:6]));
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_ff      <= 1'b1;
            sda_ff      <= 1'b1;
            lvl_sync_ff <= 9'h000;
            lvl_ff      <= 3'h0;
        end else begin
            scl_sync_ff <= nxt_scl_sync;
            sda_sync_ff <= nxt_sda_sync;
            scl_ff      <= nxt_scl;
            sda_ff      <= nxt_sda;
            lvl_sync_ff <= nxt_lvl_sync;
            lvl_ff      <= nxt_lvl;
        end
    end

    assign scl_rise  = nxt_scl & ~scl_ff;
    assign scl_fall  = ~nxt_scl & scl_ff;
    assign start_det = scl_ff & nxt_scl & sda_ff & ~nxt_sda;
    assign stop_det  = scl_ff & nxt_scl & ~sda_ff & nxt_sda;
    assign {wp_sync, brownout_sync, power_good_sync} = lvl_ff;

    // ------------------------------------------------------------------
    // power-up hold-off
    // ------------------------------------------------------------------
    // brown-out restarts the wait, so the interface stays dead meanwhile
    logic [23:0] init_cnt_ff, nxt_init_cnt;
    logic        ready_ff, nxt_ready;

    always_comb begin
        nxt_init_cnt = init_cnt_ff;
        nxt_ready    = ready_ff;
        if (brownout_sync || !power_good_sync) begin
            nxt_init_cnt = '0;
            nxt_ready    = 1'b0;
        end else if (!ready_ff) begin
            nxt_init_cnt = init_cnt_ff + 24'h1;
            nxt_ready    = (init_cnt_ff >= 24'(INIT_CYCLES - 1));
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            init_cnt_ff <= '0;
            ready_ff    <= 1'b0;
        end else begin
            init_cnt_ff <= nxt_init_cnt;
            ready_ff    <= nxt_ready;
        end
    end

    // ------------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------------
    seeb_pkg::seeb_state_t state_ff, nxt_state;
    logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
    logic [7:0]  shift_ff, nxt_shift, rx_byte;
    logic [15:0] waddr_ff, nxt_waddr;
    logic [3:0]  type_ff, nxt_type;
    logic        rd_ff, nxt_rd, ack_ff, nxt_ack;
    logic        drive_ff, nxt_drive, dout_ff, nxt_dout;
    logic        wrote_ff, nxt_wrote;
    logic [7:0]  wdata_ff, nxt_wdata;
    logic        wvalid_ff, nxt_wvalid, prog_ff, nxt_prog, rdnext_ff, nxt_rdnext;
    logic [2:0]  straps;
    logic [2:0]  fn;
    logic        wr_ok;

    assign straps  = {i_chip_select_strap_2, i_chip_select_strap_1, i_chip_select_strap_0};
    assign rx_byte = {shift_ff[6:0], sda_ff};
    assign fn      = waddr_ff[seeb_pkg::FN_MSB:seeb_pkg::FN_LSB];
    // data acceptance: protect pin vetoes all writes, id lock vetoes id page writes only
    assign wr_ok   = !wp_sync &&
                     !(type_ff == seeb_pkg::TYPE_IDPAGE && i_id_locked);

    always_comb begin
        nxt_state   = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift   = shift_ff;
        nxt_waddr   = waddr_ff;
        nxt_type    = type_ff;
        nxt_rd      = rd_ff;
        nxt_ack     = ack_ff;
        nxt_drive   = drive_ff;
        nxt_dout    = dout_ff;
        nxt_wrote   = wrote_ff;
        nxt_wdata   = wdata_ff;
        nxt_wvalid  = 1'b0;
        nxt_prog    = 1'b0;
        nxt_rdnext  = 1'b0;
        if (!ready_ff || brownout_sync) begin
            nxt_state = seeb_pkg::SEEB_IDLE;
            nxt_drive = 1'b0;
            nxt_wrote = 1'b0;
        end else if (start_det) begin
            nxt_state   = seeb_pkg::SEEB_DEVADDR;
            nxt_bit_cnt = '0;
            nxt_drive   = 1'b0;
            nxt_wrote   = 1'b0;
        end else if (stop_det) begin
            nxt_prog  = wrote_ff && !rd_ff;
            nxt_state = seeb_pkg::SEEB_IDLE;
            nxt_drive = 1'b0;
            nxt_wrote = 1'b0;
        end else if (state_ff != seeb_pkg::SEEB_IDLE && state_ff != seeb_pkg::SEEB_IGNORE) begin
            if (scl_rise) begin
                if (bit_cnt_ff < seeb_pkg::ACK_SLOT) begin
                    nxt_shift   = rx_byte;
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                end else begin
                    // ninth clock: master's ack decides whether reading goes on
                    nxt_bit_cnt = '0;
                    if (state_ff == seeb_pkg::SEEB_RDATA && sda_ff)
                        nxt_state = seeb_pkg::SEEB_IGNORE;
                end
            end else if (scl_fall) begin
                if (bit_cnt_ff == seeb_pkg::BITS_PER_BYTE) begin
                    nxt_ack = 1'b0;
                    case (state_ff)
                        seeb_pkg::SEEB_DEVADDR: begin
                            nxt_type = shift_ff[7:4];
                            nxt_rd   = shift_ff[0];
                            nxt_ack  = (shift_ff[7:4] == seeb_pkg::TYPE_ARRAY ||
                                        shift_ff[7:4] == seeb_pkg::TYPE_IDPAGE) &&
                                       shift_ff[3:1] == straps && !i_busy;
                            nxt_state = !nxt_ack ? seeb_pkg::SEEB_IGNORE :
                                        shift_ff[0] ? seeb_pkg::SEEB_RDATA : seeb_pkg::SEEB_WADDR_HI;
                            nxt_rdnext = nxt_ack && shift_ff[0];
                        end
                        seeb_pkg::SEEB_WADDR_HI: begin
                            nxt_waddr[15:8] = shift_ff;
                            nxt_ack   = 1'b1;
                            nxt_state = seeb_pkg::SEEB_WADDR_LO;
                        end
                        seeb_pkg::SEEB_WADDR_LO: begin
                            nxt_waddr[7:0] = shift_ff;
                            nxt_ack   = 1'b1;
                            nxt_state = seeb_pkg::SEEB_WDATA;
                        end
                        seeb_pkg::SEEB_WDATA: begin
                            nxt_ack = wr_ok;
                            if (wr_ok) begin
                                nxt_wdata  = shift_ff;
                                nxt_wvalid = 1'b1;
                                nxt_wrote  = 1'b1;
                            end
                        end
                        seeb_pkg::SEEB_RDATA: begin
                            nxt_rdnext = 1'b1;
                        end
                        default: nxt_state = seeb_pkg::SEEB_IGNORE;
                    endcase
                    nxt_drive = nxt_ack;
                    nxt_dout  = 1'b0;
                end else if (state_ff == seeb_pkg::SEEB_RDATA) begin
                    // bit_cnt 0..7 after ninth clock: present read bits
                    nxt_drive = 1'b1;
                    nxt_dout  = i_rd_data[3'(7 - bit_cnt_ff)];
                end else begin
                    nxt_drive = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff   <= seeb_pkg::SEEB_IDLE;
            bit_cnt_ff <= '0;
            shift_ff   <= '0;
            waddr_ff   <= '0;
            type_ff    <= '0;
            rd_ff      <= 1'b0;
            ack_ff     <= 1'b0;
            drive_ff   <= 1'b0;
            dout_ff    <= 1'b1;
            wrote_ff   <= 1'b0;
            wdata_ff   <= '0;
            wvalid_ff  <= 1'b0;
            prog_ff    <= 1'b0;
            rdnext_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff   <= nxt_shift;
            waddr_ff   <= nxt_waddr;
            type_ff    <= nxt_type;
            rd_ff      <= nxt_rd;
            ack_ff     <= nxt_ack;
            drive_ff   <= nxt_drive;
            dout_ff    <= nxt_dout;
            wrote_ff   <= nxt_wrote;
            wdata_ff   <= nxt_wdata;
            wvalid_ff  <= nxt_wvalid;
            prog_ff    <= nxt_prog;
            rdnext_ff  <= nxt_rdnext;
        end
    end

    // ------------------------------------------------------------------
    // outputs and address decode
    // ------------------------------------------------------------------
    always_comb begin
        o_sel = seeb_pkg::SEEB_SEL_ARRAY;
        if (type_ff == seeb_pkg::TYPE_IDPAGE) begin
            if (fn == seeb_pkg::FN_LOCK && !rd_ff)
                o_sel = seeb_pkg::SEEB_SEL_LOCK;
            else if (fn == seeb_pkg::FN_UID && rd_ff)
                o_sel = seeb_pkg::SEEB_SEL_UID;
            else
                o_sel = seeb_pkg::SEEB_SEL_IDPAGE;
        end
    end

    assign o_sda_out       = 1'b0;
    assign o_sda_oe_n      = !(drive_ff && !dout_ff);
    assign o_word_addr     = waddr_ff;
    assign o_id_offset     = waddr_ff[6:0];
    assign o_uid_offset    = waddr_ff[3:0];
    assign o_rd_mode       = rd_ff;
    assign o_wr_data       = wdata_ff;
    assign o_wr_data_valid = wvalid_ff;
    assign o_program_start = prog_ff;
    assign o_rd_next       = rdnext_ff;
    assign o_standby       = (state_ff == seeb_pkg::SEEB_IDLE) || (state_ff == seeb_pkg::SEEB_IGNORE);
    assign o_ready         = ready_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_silent_idle;
        @(posedge i_mclk) disable iff (!i_arst_n)
        (state_ff == seeb_pkg::SEEB_IDLE) |-> o_sda_oe_n;
    endproperty
    a_silent_idle: assert property (p_silent_idle) else $error("sda driven while idle");
    property p_start_enters;
        @(posedge i_mclk) disable iff (!i_arst_n)
        (start_det && ready_ff && !brownout_sync) |=> (state_ff == seeb_pkg::SEEB_DEVADDR && bit_cnt_ff == 4'h0);
    endproperty
    a_start_enters: assert property (p_start_enters) else $error("start not taken");
    property p_stop_idles;
        @(posedge i_mclk) disable iff (!i_arst_n)
        stop_det |=> (state_ff == seeb_pkg::SEEB_IDLE);
    endproperty
    a_stop_idles: assert property (p_stop_idles) else $error("stop did not end transfer");
    property p_prog_write;
        @(posedge i_mclk) disable iff (!i_arst_n)
        o_program_start |-> $past(wrote_ff) && !$past(rd_ff);
    endproperty
    a_prog_write: assert property (p_prog_write) else $error("program without write");
    property p_drive_on_fall;
        @(posedge i_mclk) disable iff (!i_arst_n)
        $changed(o_sda_oe_n) && ready_ff |-> !scl_ff || $past(start_det || stop_det);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("sda changed with scl high");
    property p_wp_no_data;
        @(posedge i_mclk) disable iff (!i_arst_n)
        wp_sync && $past(wp_sync) |-> !o_wr_data_valid;
    endproperty
    a_wp_no_data: assert property (p_wp_no_data) else $error("data taken while protected");
    property p_brownout_silent;
        @(posedge i_mclk) disable iff (!i_arst_n)
        brownout_sync |=> o_sda_oe_n && !o_ready;
    endproperty
    a_brownout_silent: assert property (p_brownout_silent) else $error("active during brown-out");
    property p_bad_addr_nack;
        @(posedge i_mclk) disable iff (!i_arst_n)
        (state_ff == seeb_pkg::SEEB_DEVADDR && scl_fall && bit_cnt_ff == 4'h8 &&
         shift_ff[3:1] != straps) |=> o_sda_oe_n && o_standby;
    endproperty
    a_bad_addr_nack: assert property (p_bad_addr_nack) else $error("acked wrong address");
endmodule // seeb_slave

/* logic/seeb_pkg.sv */
// Purpose: constants for the serial memory bus slave front end
// Assumes: system clock of 10 MHz
// Notes:   bus pins are sampled by the system clock
package seeb_pkg;
    localparam logic [3:0]  TYPE_ARRAY    = 4'ha;
    localparam logic [3:0]  TYPE_IDPAGE   = 4'hb;
    localparam logic [2:0]  FN_IDPAGE     = 3'h0;
    localparam logic [2:0]  FN_LOCK       = 3'h2;
    localparam logic [2:0]  FN_UID        = 3'h1;
    localparam int          FN_MSB        = 11;
    localparam int          FN_LSB        = 9;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [3:0]  ACK_SLOT      = 4'h8;
    localparam int          CLK_HZ        = 10000000;
    localparam int          T_INIT_US     = 10000;
    localparam int          INIT_CYCLES   = (T_INIT_US * (CLK_HZ / 1000000));
    localparam logic [1:0]  SYNC_RST      = 2'h3;
    typedef enum logic [2:0] {SEEB_IDLE, SEEB_DEVADDR, SEEB_WADDR_HI, SEEB_WADDR_LO,
                              SEEB_WDATA, SEEB_RDATA, SEEB_IGNORE} seeb_state_t;
    typedef enum logic [1:0] {SEEB_SEL_ARRAY, SEEB_SEL_IDPAGE, SEEB_SEL_LOCK,
                              SEEB_SEL_UID} seeb_sel_t;
endpackage

/* sim/seeb_master_model.sv */
// Purpose: behavioural two-wire bus master facing the slave front end
// Assumes: open-drain line resolved outside, pulled high when released
// Notes:   scl stands high between frames; one bit lasts eight i_clk cycles
`timescale 1ns/100ps
module seeb_master_model (
    input  wire logic i_clk,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_drv
);
    // ----------------------------------------
    // bit level
    // ----------------------------------------
    initial begin
        o_scl     = 1'b1;
        o_sda_drv = 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask

    // long low phase so device output set after filtered fall is settled
    task automatic clk_bit(input logic b, output logic r);
        cyc(2);
        o_sda_drv = b;
        cyc(3);
        o_scl = 1'b1;
        cyc(3);
        r = i_sda_line;
        o_scl = 1'b0;
    endtask

    task automatic start_cond();
        cyc(2);
        o_sda_drv = 1'b1;
        cyc(3);
        o_scl = 1'b1;
        cyc(3);
        o_sda_drv = 1'b0;
        cyc(3);
        o_scl = 1'b0;
    endtask

    task automatic stop_cond();
        cyc(2);
        o_sda_drv = 1'b0;
        cyc(3);
        o_scl = 1'b1;
        cyc(3);
        o_sda_drv = 1'b1;
        cyc(3);
    endtask

    // ----------------------------------------
    // byte level
    // ----------------------------------------
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, ack);
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(nack, r);
    endtask

    task automatic recover();
        logic r;
        start_cond();
        repeat (9) clk_bit(1'b1, r);
        start_cond();
        stop_cond();
    endtask
endmodule // seeb_master_model

/* sim/seeb_slave_tb_top.sv */
// Purpose: self-checking bench of the two-wire slave front end
// Assumes: straps start at 3'h5; short power-up hold-off of 20 cycles
// Notes:   read sequences beyond one byte are not exercised
`timescale 1ns/100ps
module seeb_slave_tb_top;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    logic        i_mclk, i_arst_n, i_power_good, i_brownout, i_write_protect, i_busy;
    logic        mst_scl, mst_sda, o_sda_out, o_sda_oe_n, o_rd_next, o_rd_mode;
    logic        o_wr_data_valid, o_program_start, o_standby, o_ready;
    logic [7:0]  i_rd_data, o_wr_data;
    logic [15:0] o_word_addr;
    logic [1:0]  o_sel;
    logic [6:0]  o_id_offset;
    logic [3:0]  o_uid_offset;
    logic [2:0]  straps;
    logic        id_locked;
    wire         sda_line = mst_sda & (o_sda_oe_n | o_sda_out);
    int          failures, total_checks, prog_cnt, wv_cnt, rn_cnt;

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) if (o_program_start === 1'b1) prog_cnt <= prog_cnt + 1;
    always @(posedge i_mclk) if (o_wr_data_valid === 1'b1) wv_cnt <= wv_cnt + 1;
    always @(posedge i_mclk) if (o_rd_next === 1'b1) rn_cnt <= rn_cnt + 1;

    seeb_master_model u_mst (.i_clk(i_mclk), .i_sda_line(sda_line), .o_scl(mst_scl), .o_sda_drv(mst_sda));

    seeb_slave #(.INIT_CYCLES(20)) u_dut (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_power_good(i_power_good), .i_brownout(i_brownout),
        .i_scl(mst_scl), .i_sda(sda_line), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
        .i_chip_select_strap_0(straps[0]), .i_chip_select_strap_1(straps[1]), .i_chip_select_strap_2(straps[2]),
        .i_write_protect(i_write_protect), .i_id_locked(id_locked), .i_busy(i_busy), .i_rd_data(i_rd_data),
        .o_rd_next(o_rd_next), .o_word_addr(o_word_addr), .o_sel(o_sel), .o_id_offset(o_id_offset),
        .o_uid_offset(o_uid_offset), .o_rd_mode(o_rd_mode), .o_wr_data(o_wr_data),
        .o_wr_data_valid(o_wr_data_valid), .o_program_start(o_program_start), .o_standby(o_standby),
        .o_ready(o_ready));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] ab(input logic [3:0] ty, input logic rw);
        return {ty, straps, rw};
    endfunction

    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic a;
        u_mst.write_byte(d, a);
        chk(16'(a), 16'(exp_ack));
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (o_ready !== 1'b1 && n < 200) begin
            u_mst.cyc(1);
            n++;
        end
        chk(16'(o_ready), 16'h0001);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_write();
        int p, w;
        w = wv_cnt;
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_ARRAY, 1'b0), 1'b0);
        wb(8'h12, 1'b0);
        wb(8'h34, 1'b0);
        u_mst.cyc(6);
        chk(o_word_addr, 16'h1234);
        chk(16'(o_sel), 16'h0000);
        chk(16'(o_rd_mode), 16'h0000);
        wb(8'ha5, 1'b0);
        u_mst.cyc(6);
        chk(16'(o_wr_data), 16'h00a5);
        wb(8'h3c, 1'b0);
        u_mst.cyc(6);
        chk(16'(o_wr_data), 16'h003c);
        p = prog_cnt;
        u_mst.stop_cond();
        u_mst.cyc(4);
        chk(16'(prog_cnt), 16'(p + 1));
        chk(16'(wv_cnt), 16'(w + 2));
        $display("t_write done");
    endtask

    task automatic t_refuse();
        logic [7:0] a [3];
        a = '{ab(seeb_pkg::TYPE_ARRAY, 1'b0) ^ 8'h02, 8'hc0 | ab(4'h0, 1'b0), ab(seeb_pkg::TYPE_ARRAY, 1'b0)};
        for (int i = 0; i < 3; i++) begin
            i_busy = (i == 2);
            u_mst.start_cond();
            wb(a[i], 1'b1);
            u_mst.cyc(4);
            chk(16'(o_standby), 16'h0001);
            wb(8'hff, 1'b1);
            u_mst.stop_cond();
            i_busy = 1'b0;
        end
        straps = 3'h6;
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_ARRAY, 1'b0), 1'b0);
        u_mst.stop_cond();
        straps = 3'h5;
        $display("t_refuse done");
    endtask

    task automatic t_protect();
        int p, w;
        i_write_protect = 1'b1;
        p = prog_cnt;
        w = wv_cnt;
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_ARRAY, 1'b0), 1'b0);
        wb(8'h00, 1'b0);
        wb(8'h07, 1'b0);
        wb(8'h5a, 1'b1);
        u_mst.stop_cond();
        u_mst.cyc(4);
        chk(16'(prog_cnt), 16'(p));
        chk(16'(wv_cnt), 16'(w));
        i_write_protect = 1'b0;
        $display("t_protect done");
    endtask

    task automatic t_idfn();
        logic [2:0]         fn [3];
        seeb_pkg::seeb_sel_t es [3];
        logic [7:0]         d;
        int                 p;
        fn = '{seeb_pkg::FN_IDPAGE, seeb_pkg::FN_LOCK, seeb_pkg::FN_UID};
        es = '{seeb_pkg::SEEB_SEL_IDPAGE, seeb_pkg::SEEB_SEL_LOCK, seeb_pkg::SEEB_SEL_IDPAGE};
        for (int i = 0; i < 3; i++) begin
            u_mst.start_cond();
            wb(ab(seeb_pkg::TYPE_IDPAGE, 1'b0), 1'b0);
            wb({4'hf, fn[i], 1'b1}, 1'b0);
            wb(8'hdb, 1'b0);
            u_mst.cyc(6);
            chk(16'(o_sel), 16'(es[i]));
            chk(16'(o_id_offset), 16'h005b);
            chk(16'(o_uid_offset), 16'h000b);
            u_mst.stop_cond();
        end
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_IDPAGE, 1'b1), 1'b0);
        chk(16'(o_sel), 16'(seeb_pkg::SEEB_SEL_UID));
        u_mst.read_byte(1'b1, d);
        u_mst.stop_cond();
        id_locked = 1'b1;
        p = prog_cnt;
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_IDPAGE, 1'b0), 1'b0);
        wb(8'h00, 1'b0);
        wb(8'h05, 1'b0);
        wb(8'h11, 1'b1);
        u_mst.stop_cond();
        u_mst.cyc(4);
        chk(16'(prog_cnt), 16'(p));
        id_locked = 1'b0;
        $display("t_idfn done");
    endtask

    task automatic t_read();
        logic [7:0] d;
        int         r;
        r = rn_cnt;
        i_rd_data = 8'h96;
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_ARRAY, 1'b1), 1'b0);
        u_mst.read_byte(1'b1, d);
        chk(16'(d), 16'h0096);
        chk(16'(o_rd_mode), 16'h0001);
        chk(16'(rn_cnt), 16'(r + 2));
        chk(16'(o_sda_out), 16'h0000);
        u_mst.stop_cond();
        u_mst.cyc(4);
        chk(16'(o_standby), 16'h0001);
        $display("t_read done");
    endtask

    task automatic t_brownout();
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_ARRAY, 1'b0), 1'b0);
        i_brownout = 1'b1;
        u_mst.cyc(8);
        chk(16'(o_ready), 16'h0000);
        wb(8'h00, 1'b1);
        i_brownout = 1'b0;
        wait_ready();
        i_power_good = 1'b0;
        u_mst.cyc(8);
        chk(16'(o_ready), 16'h0000);
        i_power_good = 1'b1;
        wait_ready();
        u_mst.recover();
        u_mst.start_cond();
        wb(ab(seeb_pkg::TYPE_ARRAY, 1'b0), 1'b0);
        u_mst.stop_cond();
        $display("t_brownout done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        failures = 0;
        total_checks = 0;
        prog_cnt = 0;
        wv_cnt = 0;
        rn_cnt = 0;
        straps = 3'h5;
        id_locked = 1'b0;
        i_arst_n = 1'b0;
        i_power_good = 1'b1;
        i_brownout = 1'b0;
        i_write_protect = 1'b0;
        i_busy = 1'b0;
        i_rd_data = 8'h00;
        u_mst.cyc(6);
        i_arst_n = 1'b1;
        wait_ready();
        t_write();
        t_refuse();
        t_protect();
        t_idfn();
        t_read();
        t_brownout();
        finish_test();
    end

    initial begin
        #3000000;
        failures++;
        finish_test();
    end
endmodule // seeb_slave_tb_top
